// >>> verilog/iom_pkg.sv
/*
 * Package for the I/O option-map register bank: offsets, field positions,
 * reset values and the packed carriers for configuration outputs.
 * Assumes an Avalon-MM slave with 32-bit data, one register per word.
 */
package iom_pkg;

    // Register indices (byte address = 4 * index)
    localparam logic [3:0] IOM_IDX_DIR_A     = 4'h0;
    localparam logic [3:0] IOM_IDX_DIR_C     = 4'h2;
    localparam logic [3:0] IOM_IDX_PD_SEL    = 4'h3;
    localparam logic [3:0] IOM_IDX_PE_SEL    = 4'h4;
    localparam logic [3:0] IOM_IDX_PULL_AB   = 4'h8;
    localparam logic [3:0] IOM_IDX_PULL_C    = 4'h9;
    localparam logic [3:0] IOM_IDX_OD_ADE    = 4'ha;
    localparam logic [3:0] IOM_IDX_OD_C      = 4'hb;
    localparam logic [3:0] IOM_IDX_WAKE_EN   = 4'he;
    localparam logic [3:0] IOM_IDX_FACTORY   = 4'hf;
    // Miscellaneous control register, outside the overlaid window
    localparam logic [5:0] IOM_IDX_MISC      = 6'h3e;

    // Miscellaneous register field
    localparam int IOM_MISC_SEL_BIT = 0;

    // Writable masks, fixed-one bits of open_drain_ctrl_c, and the factory status bit mask
    localparam logic [7:0] IOM_PD_SEL_MASK   = 8'hf0;
    localparam logic [7:0] IOM_PULL_AB_MASK  = 8'h0f;
    localparam logic [7:0] IOM_OD_ADE_MASK   = 8'hf3;
    localparam logic [7:0] IOM_OD_C_MASK     = 8'h3f;
    localparam logic [7:0] IOM_OD_C_FIXED    = 8'hc0;
    localparam logic [7:0] IOM_FACTORY_MASK  = 8'he0;

    // Reset values
    localparam logic [7:0] IOM_RST_ZERO      = 8'h00;
    localparam logic [7:0] IOM_RST_OD_C      = 8'hc0;

    // Field positions in pullup_ctrl_ab
    localparam int IOM_PB_UPPER_PULLUP = 3;
    localparam int IOM_PB_LOWER_PULLUP = 2;
    localparam int IOM_PA_UPPER_PULLUP = 1;
    localparam int IOM_PA_LOWER_PULLUP = 0;
    // Field positions in open_drain_ctrl_ade
    localparam int IOM_PD_UPPER_OD     = 7;
    localparam int IOM_PD_LOWER_OD     = 6;
    localparam int IOM_PE_UPPER_OD     = 5;
    localparam int IOM_PE_LOWER_OD     = 4;
    localparam int IOM_PA_UPPER_OD     = 1;
    localparam int IOM_PA_LOWER_OD     = 0;
    // Field positions in factory_option_status
    localparam int IOM_RESET_PIN_PULLUP_OPT = 7;
    localparam int IOM_MAIN_OSC_RES_OPT     = 6;
    localparam int IOM_SECOND_OSC_RES_OPT   = 5;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
    } iom_pullup_type;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pc;
        logic [7:0] pd;
        logic [7:0] pe;
    } iom_open_drain_type;

endpackage

// >>> verilog/iom_option_map.sv
/*
 * I/O option-map register bank with an Avalon-MM slave port.
 * Assumes sys_clk at 100 MHz, synchronous active-low reset, and that the
 * display controller supplies its port-select bits and backplane usage.
 */
// Added by the designer: register access over Avalon-MM.
// Operation
// - Select bit set: indices 0..F reach option map, main registers hidden
// - Factory option status register sits at option-map index F
// - Two pullup_ctrl_ab bits enable port B upper and lower pullups, reset 0
// - Two pullup_ctrl_ab bits enable port A upper and lower pullups, reset 0
// - Each pullup_ctrl_c bit enables its port C pin pullup, reset 0
// - Port D upper open-drain applies only where display selects port output
// - Port D lower open-drain per pin only if its backplane is unused
// - Port E half open-drain only where display selects general output
// - Port A half open-drain only on pins whose direction is output
// - open_drain_ctrl_c bits 7,6 read 1; port C pins 6,7 open-drain whenever direction is output
// - Port C bits 0..5 open-drain when direction is output, reset 0
// - Each wakeup enable bit enables its port B wakeup input, reset 0
// - Factory status reports three option bits; low five bits read 0
// - Unused bits of open-drain and pullup registers read 0
`timescale 1ns/100ps
`default_nettype none

module iom_option_map
    import iom_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic [31:0]        main_readdata,
    output logic                    main_write,
    output logic                    main_read,
    output logic [5:0]              main_index,
    output logic [7:0]              main_writedata,
    input  wire logic               reset_pin_pullup_option,
    input  wire logic               main_osc_resistor_option,
    input  wire logic               second_osc_resistor_option,
    input  wire logic               pd_upper_port_select,
    input  wire logic               pe_upper_port_select,
    input  wire logic               pe_lower_port_select,
    input  wire logic [2:0]         backplane_pin_in_use,
    output logic [7:0]              port_a_direction,
    output logic [7:0]              port_c_direction,
    output logic [7:0]              port_d_pin_select,
    output logic [7:0]              port_e_pin_select,
    output logic [7:0]              wakeup_input_enable,
    output logic                    option_map_select,
    output iom_pullup_type          pullup_en,
    output iom_open_drain_type      open_drain_en
);

    logic [7:0] dir_a_q, dir_c_q, pd_sel_q, pe_sel_q;
    logic [7:0] pull_ab_q, pull_c_q, od_ade_q, od_c_q, wake_q;
    logic       sel_q;
    logic [7:0] factory_q;
    logic       ack_q;
    logic [31:0] rdata_q;
    logic       mwr_q, mrd_q;
    logic [5:0] midx_q;
    logic [7:0] mwd_q;
    iom_pullup_type     pull_q;
    iom_open_drain_type od_q;

    // One wait state: a request is answered on the cycle after it is seen
    wire        req        = (avs_read | avs_write) & ~ack_q;
    wire [5:0]  idx        = avs_address[7:2];
    wire        low_window = (idx[5:4] == 2'b00);
    wire        opt_hit    = sel_q & low_window;
    wire        misc_hit   = (idx == IOM_IDX_MISC);
    wire        main_hit   = ~opt_hit & ~misc_hit;
    wire        wr_lane    = avs_write & req & avs_byteenable[0];
    wire [7:0]  wd         = avs_writedata[7:0];
    wire        wr_opt     = wr_lane & opt_hit;
    wire        wr_dir_a   = wr_opt & (idx[3:0] == IOM_IDX_DIR_A);
    wire        wr_dir_c   = wr_opt & (idx[3:0] == IOM_IDX_DIR_C);
    wire        wr_pd_sel  = wr_opt & (idx[3:0] == IOM_IDX_PD_SEL);
    wire        wr_pe_sel  = wr_opt & (idx[3:0] == IOM_IDX_PE_SEL);
    wire        wr_pull_ab = wr_opt & (idx[3:0] == IOM_IDX_PULL_AB);
    wire        wr_pull_c  = wr_opt & (idx[3:0] == IOM_IDX_PULL_C);
    wire        wr_od_ade  = wr_opt & (idx[3:0] == IOM_IDX_OD_ADE);
    wire        wr_od_c    = wr_opt & (idx[3:0] == IOM_IDX_OD_C);
    wire        wr_wake    = wr_opt & (idx[3:0] == IOM_IDX_WAKE_EN);
    wire        wr_misc    = wr_lane & misc_hit;

    logic [7:0] opt_rd;
    always_comb begin
        case (idx[3:0])
            IOM_IDX_DIR_A:   opt_rd = dir_a_q;
            IOM_IDX_DIR_C:   opt_rd = dir_c_q;
            IOM_IDX_PD_SEL:  opt_rd = pd_sel_q;
            IOM_IDX_PE_SEL:  opt_rd = pe_sel_q;
            IOM_IDX_PULL_AB: opt_rd = pull_ab_q;
            IOM_IDX_PULL_C:  opt_rd = pull_c_q;
            IOM_IDX_OD_ADE:  opt_rd = od_ade_q;
            IOM_IDX_OD_C:    opt_rd = od_c_q | IOM_OD_C_FIXED;
            IOM_IDX_WAKE_EN: opt_rd = wake_q;
            IOM_IDX_FACTORY: opt_rd = factory_q;
            default:         opt_rd = IOM_RST_ZERO;
        endcase
    end

    // Option bits are mask-fixed; sampled every cycle, low bits forced to 0
    wire [7:0] factory_d = {reset_pin_pullup_option, main_osc_resistor_option,
                            second_osc_resistor_option, 5'h00} & IOM_FACTORY_MASK;

    wire [31:0] rd_d = opt_hit  ? {24'h000000, opt_rd} :
                       misc_hit ? {31'h00000000, sel_q} :
                                  main_readdata;

    // Derived configuration
    wire [7:0] pb_pull = {{4{pull_ab_q[IOM_PB_UPPER_PULLUP]}},
                          {4{pull_ab_q[IOM_PB_LOWER_PULLUP]}}};
    wire [7:0] pa_pull = {{4{pull_ab_q[IOM_PA_UPPER_PULLUP]}},
                          {4{pull_ab_q[IOM_PA_LOWER_PULLUP]}}};
    wire [7:0] pa_od   = dir_a_q & {{4{od_ade_q[IOM_PA_UPPER_OD]}},
                                    {4{od_ade_q[IOM_PA_LOWER_OD]}}};
    wire [7:0] pc_od   = dir_c_q & (od_c_q | IOM_OD_C_FIXED);
    wire [3:0] pd_up   = {4{od_ade_q[IOM_PD_UPPER_OD] & pd_upper_port_select}};
    wire [2:0] pd_lo   = {3{od_ade_q[IOM_PD_LOWER_OD]}} & ~backplane_pin_in_use;
    wire [7:0] pe_od   = {{4{od_ade_q[IOM_PE_UPPER_OD] & pe_upper_port_select}},
                          {4{od_ade_q[IOM_PE_LOWER_OD] & pe_lower_port_select}}};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dir_a_q   <= IOM_RST_ZERO;
            dir_c_q   <= IOM_RST_ZERO;
            pd_sel_q  <= IOM_RST_ZERO;
            pe_sel_q  <= IOM_RST_ZERO;
            pull_ab_q <= IOM_RST_ZERO;
            pull_c_q  <= IOM_RST_ZERO;
            od_ade_q  <= IOM_RST_ZERO;
            od_c_q    <= IOM_RST_OD_C;
            wake_q    <= IOM_RST_ZERO;
            sel_q     <= 1'b0;
        end else begin
            if (wr_dir_a)   dir_a_q   <= wd;
            if (wr_dir_c)   dir_c_q   <= wd;
            if (wr_pd_sel)  pd_sel_q  <= wd & IOM_PD_SEL_MASK;
            if (wr_pe_sel)  pe_sel_q  <= wd;
            if (wr_pull_ab) pull_ab_q <= wd & IOM_PULL_AB_MASK;
            if (wr_pull_c)  pull_c_q  <= wd;
            if (wr_od_ade)  od_ade_q  <= wd & IOM_OD_ADE_MASK;
            if (wr_od_c)    od_c_q    <= (wd & IOM_OD_C_MASK) | IOM_OD_C_FIXED;
            if (wr_wake)    wake_q    <= wd;
            if (wr_misc)    sel_q     <= wd[IOM_MISC_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q     <= 1'b0;
            rdata_q   <= 32'h00000000;
            factory_q <= IOM_RST_ZERO;
            mwr_q     <= 1'b0;
            mrd_q     <= 1'b0;
            midx_q    <= 6'h00;
            mwd_q     <= IOM_RST_ZERO;
            pull_q    <= '0;
            od_q      <= '0;
        end else begin
            ack_q     <= req;
            if (req & avs_read) rdata_q <= rd_d;
            factory_q <= factory_d;
            // Main space forwarded only when not shadowed by the option map
            mwr_q     <= wr_lane & main_hit;
            mrd_q     <= req & avs_read & main_hit;
            midx_q    <= idx;
            mwd_q     <= wd;
            pull_q    <= '{pa: pa_pull, pb: pb_pull, pc: pull_c_q};
            od_q      <= '{pa: pa_od, pc: pc_od, pd: {pd_up, pd_lo, 1'b0}, pe: pe_od};
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    end

    assign avs_readdata        = rdata_q;
    assign main_write          = mwr_q;
    assign main_read           = mrd_q;
    assign main_index          = midx_q;
    assign main_writedata      = mwd_q;
    assign port_a_direction    = dir_a_q;
    assign port_c_direction    = dir_c_q;
    assign port_d_pin_select   = pd_sel_q;
    assign port_e_pin_select   = pe_sel_q;
    assign wakeup_input_enable = wake_q;
    assign option_map_select   = sel_q;
    assign pullup_en           = pull_q;
    assign open_drain_en       = od_q;

endmodule

`default_nettype wire

// >>> testbench/iom_option_map_asserts.sv
/* Port checker for the option-map bank.
   Assumes it is bound to every iom_option_map instance. */
`timescale 1ns/100ps
`default_nettype none
module iom_option_map_asserts
    import iom_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic [7:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire logic               main_write,
    input wire logic               main_read,
    input wire logic [5:0]         main_index,
    input wire logic               option_map_select,
    input wire logic [7:0]         port_a_direction,
    input wire logic [7:0]         port_c_direction,
    input wire logic               pd_upper_port_select,
    input wire logic               pe_upper_port_select,
    input wire logic               pe_lower_port_select,
    input wire logic [2:0]         backplane_pin_in_use,
    input wire iom_pullup_type     pullup_en,
    input wire iom_open_drain_type open_drain_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        avs_waitrequest && (avs_read || avs_write);
    endsequence
    sequence s_om_rd(logic [5:0] i);
        s_take ##0 avs_read && option_map_select && avs_address[7:2] == i;
    endsequence
    // Read data is registered at the edge where the request is taken,
    // so it is first visible to sampling one edge later and still held at the next
    property p_rd(logic [5:0] i, logic [31:0] m, logic [31:0] v);
        s_om_rd(i) |=> ##1 (avs_readdata & m) == v;
    endproperty
    a_map_hides: assert property (s_take ##0 option_map_select && avs_address[7:6] == 2'h0
        |=> !main_write && !main_read) else $error("main access while map selected");
    a_map_fwd: assert property (s_take ##0 avs_read && !option_map_select
        && avs_address[7:2] == 6'h0 |=> main_read && main_index == 6'h0) else $error("no main read");
    a_fact_zero: assert property (p_rd(6'hf, 32'hffffff1f, 32'h0))
        else $error("factory status stray bits");
    a_odc_fixed: assert property (p_rd(6'hb, 32'h000000c0, 32'h000000c0))
        else $error("fixed open-drain bits not 1");
    a_unused_ab: assert property (p_rd(6'h8, 32'hfffffff0, 32'h0))
        else $error("pullup unused bits set");
    a_unused_ade: assert property (p_rd(6'ha, 32'hffffff0c, 32'h0))
        else $error("open-drain unused bits set");
    a_pc_od_dir: assert property ((open_drain_en.pc & ~$past(port_c_direction)) == 8'h0)
        else $error("port c open-drain on input");
    a_pc_od_fix: assert property ($past(rst_n) && $past(port_c_direction[7:6]) == 2'h3
        |-> open_drain_en.pc[7:6] == 2'h3) else $error("port c 7,6 not open-drain");
    a_pa_od_dir: assert property ((open_drain_en.pa & ~$past(port_a_direction)) == 8'h0)
        else $error("port a open-drain on input");
    a_pd_od_gate: assert property (open_drain_en.pd[0] == 1'b0
        && (open_drain_en.pd[3:1] & $past(backplane_pin_in_use)) == 3'h0
        && (open_drain_en.pd[7:4] == 4'h0 || $past(pd_upper_port_select)
        && open_drain_en.pd[7:4] == 4'hf)) else $error("port d open-drain gating");
    a_pe_od_gate: assert property ((open_drain_en.pe[7:4] == 4'h0
        || $past(pe_upper_port_select) && open_drain_en.pe[7:4] == 4'hf)
        && (open_drain_en.pe[3:0] == 4'h0 || $past(pe_lower_port_select)
        && open_drain_en.pe[3:0] == 4'hf)) else $error("port e open-drain gating");
    a_pullup_half: assert property (pullup_en.pa[7:4] == {4{pullup_en.pa[4]}}
        && pullup_en.pa[3:0] == {4{pullup_en.pa[0]}} && pullup_en.pb[7:4] == {4{pullup_en.pb[4]}}
        && pullup_en.pb[3:0] == {4{pullup_en.pb[0]}}) else $error("pullup half split");
endmodule
bind iom_option_map iom_option_map_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .main_write(main_write),
    .main_read(main_read), .main_index(main_index), .option_map_select(option_map_select),
    .port_a_direction(port_a_direction), .port_c_direction(port_c_direction),
    .pd_upper_port_select(pd_upper_port_select), .pe_upper_port_select(pe_upper_port_select),
    .pe_lower_port_select(pe_lower_port_select), .backplane_pin_in_use(backplane_pin_in_use),
    .pullup_en(pullup_en), .open_drain_en(open_drain_en));
`default_nettype wire

// >>> testbench/tb_iom_option_map.sv
/* Self-checking bench for the option-map bank.
   Drives the Avalon-MM slave, straps and display inputs directly. */
`timescale 1ns/100ps
`default_nettype none
module tb_iom_option_map;
    import iom_pkg::*;
    logic               sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0]         avs_address, wake_en;
    logic [31:0]        avs_writedata, avs_readdata, q;
    logic [3:0]         avs_byteenable;
    logic [2:0]         straps, disp, bp_use;
    iom_pullup_type     pullup_en;
    iom_open_drain_type open_drain_en;
    int                 fails, n_checks, cyc;
    logic [7:0]         ofs [9] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h38};
    logic [7:0]         rstv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
    logic [7:0]         ffv [9] = '{8'hff, 8'hff, 8'hf0, 8'hff, 8'h0f, 8'hff, 8'hf3, 8'hff, 8'hff};
    iom_option_map dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .main_readdata(32'h000000a5), .main_write(),
        .main_read(), .main_index(), .main_writedata(), .reset_pin_pullup_option(straps[2]),
        .main_osc_resistor_option(straps[1]), .second_osc_resistor_option(straps[0]),
        .pd_upper_port_select(disp[2]), .pe_upper_port_select(disp[1]),
        .pe_lower_port_select(disp[0]), .backplane_pin_in_use(bp_use), .port_a_direction(),
        .port_c_direction(), .port_d_pin_select(), .port_e_pin_select(),
        .wakeup_input_enable(wake_en), .option_map_select(), .pullup_en(pullup_en),
        .open_drain_en(open_drain_en));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b1, a, 8'h00, 4'hf);
        chk(q, exp);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        straps = 3'h5;
        disp = 3'h6;
        bp_use = 3'h2;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(8'h00, 32'h000000a5);
        wr(8'h00, 8'h33);
        wr(8'hf8, 8'h01);
        for (int i = 0; i < 9; i++) rdc(ofs[i], {24'h0, rstv[i]});
        for (int i = 0; i < 9; i++) wr(ofs[i], 8'hff);
        for (int i = 0; i < 9; i++) rdc(ofs[i], {24'h0, ffv[i]});
        repeat (2) @(posedge sys_clk);
        chk({8'h0, pullup_en}, 32'h00ffffff);
        chk(open_drain_en, 32'hfffffaf0);
        chk({24'h0, wake_en}, 32'h000000ff);
        bus(1'b0, 8'h00, 8'h5a, 4'he);
        rdc(8'h00, 32'h000000ff);
        rdc(8'h04, 32'h00000000);
        rdc(8'h3c, 32'h000000a0);
        wr(8'h3c, 8'h00);
        rdc(8'h3c, 32'h000000a0);
        for (int i = 0; i < 9; i++) wr(ofs[i], 8'h00);
        for (int i = 0; i < 9; i++) rdc(ofs[i], {24'h0, rstv[i]});
        wr(8'h20, 8'h06);
        wr(8'h08, 8'hff);
        repeat (2) @(posedge sys_clk);
        chk({8'h0, pullup_en}, 32'h00f00f00);
        chk(open_drain_en, 32'h00c00000);
        wr(8'hf8, 8'h00);
        rdc(8'h00, 32'h000000a5);
        report_and_stop();
    end
endmodule
`default_nettype wire
